// ---- logic/arb_pkg.sv ----
package arb_pkg;

	// ------------------------------------------------------------
	// Arbiter states
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ARB_OWN,
		ARB_GRANT,
		ARB_HOLD,
		ARB_RELEASE,
		ARB_RETURN
	} arb_state_t;

	// ------------------------------------------------------------
	// Reset values and prefetch gap
	// ------------------------------------------------------------
	localparam logic RST_GRANT = 1'b0;
	localparam logic RST_DRIVE = 1'b0;
	localparam logic [1:0] PREFETCH_GAP = 2'h2;

	// ------------------------------------------------------------
	// Request from the sequencer and bus status to the pins
	// ------------------------------------------------------------
	typedef struct packed {
		logic instr_req;
		logic data_req;
		logic operand_first;
		logic rmw_seq;
	} cyc_req_t;

	typedef struct packed {
		logic early_cycle_start;
		logic operand_cycle_start;
		logic address_strobe;
		logic rmw_indicator;
		logic size_apply;
	} cyc_out_t;

endpackage

// ---- logic/bus_arbitration_and_cache_abort.sv ----
// Overview of operation
// - Cached normal reads ignore low address and size outputs.
// - Instruction need starts cache lookup and a speculative bus cycle.
// - A hit abandons the speculative cycle; address strobe stays low.
// - Early start and operand start strobes assert when bus is free.
// - Early start strobe may stay asserted up to two consecutive clocks.
// - Instruction prefetches issue at most every other clock.
// - Aborted cycles during busy bus show no strobe activity.
// - Arbiter advances on the rising edge after request is valid.
// - Bus grant output changes on the falling edge after grant changes.
// - Bus control outputs drive right after mastership returns.
// - State 0: grant and drive negated, processor owns bus.
// - Request enters state 1 with grant and drive, then state 2.
// - State 2 holds until request drops, then state 3 negates grant.
// - State 4 follows state 3 with drive held; then back to 0.
// - Bus request ignored during read-modify-write sequences.
// - Read-modify-write indicator spans first to final sequence cycle.
// - Address strobe asserts half a clock after a cycle proceeds.
module bus_arbitration_and_cache_abort (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Sequencer side
	input wire arb_pkg::cyc_req_t req,
	input wire logic cache_enable,
	input wire logic cache_hit,
	input wire logic cycle_done,
	// External bus
	input wire logic bus_request_in,
	input wire logic bus_fault_in,
	input wire logic size_ack_hi,
	input wire logic size_ack_lo,
	output arb_pkg::cyc_out_t cyc_out,
	output logic bus_grant_out,
	output logic bus_drive_en,
	output logic cycle_aborted
);

	// All checks below sample on the rising edge and rest during reset.
	default clocking cb_sys @(posedge clk_sys);
	endclocking
	default disable iff (reset);

	// ------------------------------------------------------------
	// Cycle start and cache abort
	// ------------------------------------------------------------
	logic busy_r;
	logic strobe_pend_r;
	logic as_r;
	logic rmw_r;
	logic [1:0] pf_gap_r;
	logic ecs_r;
	logic ocs_r;
	logic abort_r;
	logic size_apply_r;
	logic bus_free;
	logic pf_ok;
	logic instr_go;
	logic start;
	logic proceed;
	logic ack;
	logic rmw_lock;

	assign ack = size_ack_hi | size_ack_lo;
	assign bus_free = ~busy_r & ~bus_drive_en;
	// Prefetches are spaced so a start right after an abort is a data fetch.
	assign pf_ok = (pf_gap_r == 2'h0);
	assign instr_go = req.instr_req & pf_ok;
	assign start = bus_free & (instr_go | req.data_req);
	// A hit only cancels a pure instruction start; data cycles go on.
	assign proceed = start & ~(instr_go & ~req.data_req & cache_hit);
	assign rmw_lock = rmw_r | (start & req.rmw_seq);

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			busy_r <= 1'b0;
			strobe_pend_r <= 1'b0;
			rmw_r <= 1'b0;
			pf_gap_r <= 2'h0;
			ecs_r <= 1'b0;
			ocs_r <= 1'b0;
			abort_r <= 1'b0;
			size_apply_r <= 1'b1;
		end else begin
			ecs_r <= start;
			ocs_r <= start & req.operand_first;
			// Hits while busy never reach the pins.
			abort_r <= start & ~proceed;
			strobe_pend_r <= proceed;
			if (proceed)
				busy_r <= 1'b1;
			else if (cycle_done | ack | bus_fault_in)
				busy_r <= 1'b0;
			if (start & req.rmw_seq)
				rmw_r <= 1'b1;
			else if (bus_fault_in | (~req.rmw_seq & ~busy_r))
				rmw_r <= 1'b0;
			if (instr_go & start)
				pf_gap_r <= arb_pkg::PREFETCH_GAP - 2'h1;
			else if (pf_gap_r != 2'h0)
				pf_gap_r <= pf_gap_r - 2'h1;
			if (proceed)
				size_apply_r <= ~(cache_enable & instr_go);
		end
	end

	// Strobe rises half a clock into the cycle, on the falling edge.
	always_ff @(negedge clk_sys) begin
		if (reset)
			as_r <= 1'b0;
		else
			as_r <= (strobe_pend_r | (as_r & busy_r)) & busy_r;
	end

	// ------------------------------------------------------------
	// Arbiter
	// ------------------------------------------------------------
	arb_pkg::arb_state_t st_r;
	arb_pkg::arb_state_t st_nxt;
	logic req_eff;
	logic grant_int;
	logic grant_fall_r;

	// Locked sequences mask the request entirely.
	assign req_eff = bus_request_in & ~rmw_lock;

	always_comb begin
		st_nxt = st_r;
		case (st_r)
			arb_pkg::ARB_OWN:
				// A start on this edge keeps the bus, or its strobe is lost.
				if (req_eff & ~busy_r & ~start)
					st_nxt = arb_pkg::ARB_GRANT;
			arb_pkg::ARB_GRANT:
				st_nxt = arb_pkg::ARB_HOLD;
			arb_pkg::ARB_HOLD:
				if (~bus_request_in)
					st_nxt = arb_pkg::ARB_RELEASE;
			arb_pkg::ARB_RELEASE:
				st_nxt = arb_pkg::ARB_RETURN;
			arb_pkg::ARB_RETURN:
				st_nxt = arb_pkg::ARB_OWN;
			default:
				st_nxt = arb_pkg::ARB_OWN;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (reset)
			st_r <= arb_pkg::ARB_OWN;
		else
			st_r <= st_nxt;
	end

	assign grant_int = (st_r == arb_pkg::ARB_GRANT) |
		(st_r == arb_pkg::ARB_HOLD);
	// Drive stays high through release so the bus is not left floating.
	assign bus_drive_en = (st_r != arb_pkg::ARB_OWN);

	always_ff @(negedge clk_sys) begin
		if (reset)
			grant_fall_r <= arb_pkg::RST_GRANT;
		else
			grant_fall_r <= grant_int;
	end

	assign bus_grant_out = grant_fall_r;
	assign cycle_aborted = abort_r;
	assign cyc_out.early_cycle_start = ecs_r & ~bus_drive_en;
	assign cyc_out.operand_cycle_start = ocs_r & ~bus_drive_en;
	assign cyc_out.address_strobe = as_r & ~bus_drive_en;
	assign cyc_out.rmw_indicator = rmw_r;
	assign cyc_out.size_apply = size_apply_r;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	// Arbiter sequence.
	AST_IDLE_STAYS: assert property (
		st_r == arb_pkg::ARB_OWN && !bus_request_in |=>
		st_r == arb_pkg::ARB_OWN)
		else $error("Arbiter left idle without request.");
	AST_GRANT_SEQ: assert property (
		st_r == arb_pkg::ARB_GRANT |=>
		st_r == arb_pkg::ARB_HOLD)
		else $error("Grant state did not move to hold.");
	AST_RELEASE: assert property (
		st_r == arb_pkg::ARB_HOLD && !bus_request_in |=>
		st_r == arb_pkg::ARB_RELEASE ##1 st_r == arb_pkg::ARB_RETURN)
		else $error("Release sequence broken.");
	AST_RETURN: assert property (
		st_r == arb_pkg::ARB_RETURN |=>
		st_r == arb_pkg::ARB_OWN && !bus_drive_en)
		else $error("Return to idle failed.");
	AST_DRIVE_RETURN: assert property (
		st_r == arb_pkg::ARB_RETURN |->
		bus_drive_en && !grant_int)
		else $error("Drive dropped before return.");
	AST_GRANT_EDGE: assert property (
		$rose(grant_int) |->
		##1 bus_grant_out)
		else $error("Grant output late.");
	AST_GRANT_MATCH: assert property (
		1'b1 |->
		bus_grant_out == grant_int)
		else $error("Grant output not half a clock behind.");
	AST_RELEASE_DROP: assert property (
		st_r == arb_pkg::ARB_RELEASE |=>
		!bus_grant_out)
		else $error("Grant output held after release.");
	AST_STEP_ONE: assert property (
		st_r == arb_pkg::ARB_OWN && req_eff && !busy_r && !start |=>
		st_r == arb_pkg::ARB_GRANT)
		else $error("Arbiter slow to take request.");
	AST_RESET_IDLE: assert property (
		$fell(reset) |->
		st_r == arb_pkg::ARB_OWN && !bus_drive_en && !bus_grant_out)
		else $error("Reset did not idle arbiter.");

	// Locked sequences.
	AST_RMW_NOGRANT: assert property (
		rmw_r && st_r == arb_pkg::ARB_OWN |=>
		st_r == arb_pkg::ARB_OWN)
		else $error("Arbitration during locked sequence.");
	AST_LOCK_NO_GRANT: assert property (
		rmw_lock && st_r == arb_pkg::ARB_OWN |=>
		!grant_int)
		else $error("Grant raised inside a lock.");
	AST_RMW_SET: assert property (
		start && req.rmw_seq |=>
		cyc_out.rmw_indicator)
		else $error("Lock indicator missing on first cycle.");
	AST_RMW_HOLD: assert property (
		rmw_r && req.rmw_seq && !bus_fault_in |=>
		rmw_r)
		else $error("Lock indicator dropped early.");
	AST_FAULT_UNLOCK: assert property (
		bus_fault_in && !(start && req.rmw_seq) |=>
		!cyc_out.rmw_indicator)
		else $error("Bus fault did not break the lock.");

	// Cycle starts, strobes and aborts.
	AST_NO_START_BUSY: assert property (
		busy_r || bus_drive_en |->
		!start)
		else $error("Cycle started on an occupied bus.");
	AST_ECS_FOLLOWS: assert property (
		start |=>
		cyc_out.early_cycle_start)
		else $error("Early start strobe missing.");
	AST_OCS_WITH_ECS: assert property (
		cyc_out.operand_cycle_start |->
		cyc_out.early_cycle_start)
		else $error("Operand start without early start.");
	AST_DRIVE_GATES: assert property (
		bus_drive_en |->
		!cyc_out.early_cycle_start && !cyc_out.address_strobe)
		else $error("Strobes driven while bus is given away.");
	AST_AS_HALF: assert property (
		proceed |=>
		cyc_out.address_strobe)
		else $error("Address strobe missing half a clock in.");
	AST_AS_ONLY_BUSY: assert property (
		cyc_out.address_strobe |->
		busy_r)
		else $error("Address strobe outside a bus cycle.");
	AST_BUSY_CLEAR: assert property (
		busy_r && (cycle_done || ack || bus_fault_in) |=>
		!busy_r)
		else $error("Bus cycle not ended on its answer.");
	AST_HIT_ABORT: assert property (
		start && instr_go && !req.data_req && cache_hit |=>
		cycle_aborted)
		else $error("Cache hit did not abort the cycle.");
	AST_HIT_NO_AS: assert property (
		start && !proceed |=>
		!strobe_pend_r ##1 !cyc_out.address_strobe)
		else $error("Strobe on aborted cycle.");
	AST_PF_GAP: assert property (
		instr_go && start |=>
		!instr_go)
		else $error("Prefetches back to back.");
	AST_ABORT_DATA: assert property (
		cycle_aborted |->
		!instr_go)
		else $error("Prefetch right after an aborted fetch.");
	AST_ABORT_QUIET: assert property (
		cycle_aborted |->
		!busy_r && !cyc_out.address_strobe)
		else $error("Aborted cycle showed on the bus.");
	AST_SIZE_CACHED: assert property (
		proceed && cache_enable && instr_go |=>
		!cyc_out.size_apply)
		else $error("Size bits marked valid on a cached read.");

	// Main scenarios.
	COV_HANDOFF: cover property (
		st_r == arb_pkg::ARB_HOLD ##1 st_r == arb_pkg::ARB_RELEASE);
	COV_ABORT: cover property (
		abort_r ##1 ecs_r);
	COV_RMW_REQ: cover property (
		rmw_r && bus_request_in);
	COV_ECS_TWICE: cover property (
		cyc_out.early_cycle_start ##1 cyc_out.early_cycle_start);
	COV_FAULT_UNLOCK: cover property (
		rmw_r && bus_fault_in);

endmodule

// ---- verification/far_side.sv ----
// ----
// Memory and peripheral responder
// ----
module far_side (
	// Clock
	input wire logic clk_sys,
	// Bus side
	input wire logic address_strobe,
	input wire logic [1:0] sel,
	output logic cycle_done,
	output logic size_ack_hi,
	output logic size_ack_lo
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [1:0] wait_r;
	logic acked_r;
	logic fire;
	// Answers once per strobe after sel clocks, so no cycle is ended twice.
	assign fire = address_strobe && !acked_r && wait_r == sel;
	assign cycle_done = fire && sel == 2'h0;
	assign size_ack_lo = fire && sel == 2'h1;
	assign size_ack_hi = fire && sel[1];
	initial begin
		wait_r = 2'h0;
		acked_r = 1'b0;
	end
	always @(posedge clk_sys) begin
		wait_r <= (address_strobe && !acked_r) ? wait_r + 2'h1 : 2'h0;
		acked_r <= address_strobe && (acked_r || fire);
	end
endmodule

// ---- verification/bus_arbitration_and_cache_abort_tb.sv ----
module bus_arbitration_and_cache_abort_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys, reset, cache_enable, cache_hit, cycle_done;
	logic bus_request_in, bus_fault_in, size_ack_hi, size_ack_lo;
	logic bus_grant_out, bus_drive_en, cycle_aborted;
	logic [1:0] sel;
	arb_pkg::cyc_req_t req;
	arb_pkg::cyc_out_t cyc_out;
	int mismatches, samples_checked, seed, i, n;
	bus_arbitration_and_cache_abort i_dut (.clk_sys(clk_sys),
		.reset(reset), .req(req), .cache_enable(cache_enable),
		.cache_hit(cache_hit), .cycle_done(cycle_done),
		.bus_request_in(bus_request_in), .bus_fault_in(bus_fault_in),
		.size_ack_hi(size_ack_hi), .size_ack_lo(size_ack_lo),
		.cyc_out(cyc_out), .bus_grant_out(bus_grant_out),
		.bus_drive_en(bus_drive_en), .cycle_aborted(cycle_aborted));
	far_side i_far (.clk_sys(clk_sys), .address_strobe(cyc_out.address_strobe),
		.sel(sel), .cycle_done(cycle_done), .size_ack_hi(size_ack_hi),
		.size_ack_lo(size_ack_lo));
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	// ----
	// Helpers
	// ----
	task automatic tick(input int k);
		repeat (k) @(posedge clk_sys);
		#2;
	endtask
	task automatic fall;
		@(negedge clk_sys);
		#1;
	endtask
	task automatic chk(input string what, input logic seen, input logic exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %b seen %b", what, exp, seen);
		end
	endtask
	task automatic results;
		if (mismatches == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Spacing by this wait also keeps prefetches two clocks apart.
	task automatic idle_wait;
		n = 0;
		while ((cyc_out.address_strobe | bus_drive_en) !== 1'b0 && n < 20) begin
			tick(1);
			n++;
		end
		if (n == 20) begin
			mismatches++;
			results();
		end
		tick(1);
	endtask
	task automatic fetch(input logic h);
		cache_enable = h | 1'($random(seed));
		cache_hit = h;
		req.operand_first = 1'($random(seed));
		req.instr_req = 1'b1;
		tick(1);
		req.instr_req = 1'b0;
		cache_hit = 1'b0;
		chk("aborted", cycle_aborted, h);
		if (!h) begin
			chk("early", cyc_out.early_cycle_start, 1'b1);
			chk("ocs", cyc_out.operand_cycle_start, req.operand_first);
			chk("size", cyc_out.size_apply, !cache_enable);
		end
		fall();
		chk("strobe", cyc_out.address_strobe, !h);
		idle_wait();
	endtask
	task automatic arb(input int hold);
		bus_request_in = 1'b1;
		tick(1);
		chk("drive", bus_drive_en, 1'b1);
		chk("grant", bus_grant_out, 1'b0);
		fall();
		chk("grant", bus_grant_out, 1'b1);
		tick(hold);
		chk("grant", bus_grant_out, 1'b1);
		bus_request_in = 1'b0;
		tick(1);
		chk("drive", bus_drive_en, 1'b1);
		fall();
		chk("grant", bus_grant_out, 1'b0);
		tick(1);
		chk("drive", bus_drive_en, 1'b1);
		tick(1);
		chk("drive", bus_drive_en, 1'b0);
	endtask
	// ----
	// Sequence
	// ----
	initial begin
		seed = 93;
		mismatches = 0;
		samples_checked = 0;
		reset = 1'b1;
		req = '0;
		{cache_enable, cache_hit, bus_request_in, bus_fault_in} = 4'h0;
		sel = 2'h0;
		tick(3);
		reset = 1'b0;
		chk("grant", bus_grant_out, arb_pkg::RST_GRANT);
		chk("drive", bus_drive_en, arb_pkg::RST_DRIVE);
		fetch(1'b1);
		for (i = 0; i < 12; i++) begin
			sel = 2'($random(seed));
			fetch(1'($random(seed)));
			if (i % 4 == 0)
				arb(1 + i / 4);
		end
		req.data_req = 1'b1;
		req.rmw_seq = 1'b1;
		sel = 2'h3;
		tick(1);
		req.data_req = 1'b0;
		bus_request_in = 1'b1;
		tick(1);
		chk("rmw", cyc_out.rmw_indicator, 1'b1);
		tick(3);
		chk("drive", bus_drive_en, 1'b0);
		chk("grant", bus_grant_out, 1'b0);
		bus_fault_in = 1'b1;
		tick(1);
		bus_fault_in = 1'b0;
		req.rmw_seq = 1'b0;
		tick(3);
		chk("drive", bus_drive_en, 1'b1);
		bus_request_in = 1'b0;
		idle_wait();
		results();
	end
endmodule
